/* shared/xtal_trim_consts.svh */
`ifndef XTAL_TRIM_CONSTS_SVH
`define XTAL_TRIM_CONSTS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_CAP_TRIM 8'h00
`define OFS_TRIM_CTRL 8'h04
`define OFS_SYS_STATUS 8'h08
`define OFS_REF_SELECT 8'h0C
`define OFS_REF_PERIODS 8'h10
`define OFS_MEASURED 8'h14
`define OFS_FAST_RC_CTRL 8'h18
`define OFS_IRQ_STATUS 8'h1C
`define OFS_IRQ_MASK 8'h20
`define OFS_SLEEP_CTRL 8'h24

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define TRIM_CTRL_DELAY_LSB 0
`define TRIM_CTRL_SETTLE_LSB 4
`define TRIM_CTRL_XTAL_EN_BIT 8
`define REF_SEL_START_BIT 2
`define SLEEP_CTRL_RCX_BIT 0
`define SLEEP_CTRL_SLOT_LSB 16

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CAP_TRIM_RESET 11'h000
`define FAST_RC_TRIM_RESET 4'h0
`define SLOT_LEN_RESET 16'h147B

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLOCK_MHZ 40
`define TRIM_TICK_US 250
`define TRIM_TICK_CYCLES (`TRIM_TICK_US * `CLOCK_MHZ)

// ----------------------------------------------------------------
// Bus answers and decoder constants
// ----------------------------------------------------------------
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define COARSE_MIN 7'h01

`endif

/* shared/xtal_trim_pkg.sv */
`default_nettype none
package xtal_trim_pkg;

	// Switch settings of one capacitor bank
	typedef struct packed {
		logic [6:0] coarse; // Thermometer coarse switches
		logic [7:0] fine; // Binary weighted switches
	} cap_switch_type;

	// Oscillator outputs fed to the reference counter
	typedef struct packed {
		logic slow_rc_osc; // Code 0x4
		logic fast_rc_osc; // Code 0x5
		logic slow_crystal; // Code 0x6
		logic enhanced_rc_osc; // Code 0x7
	} osc_ref_type;

	// Automated trim sequence
	typedef enum logic [1:0] {
		SEQ_OFF,
		SEQ_TRIM_WAIT,
		SEQ_SETTLE_WAIT,
		SEQ_DONE
	} trim_seq_type;

endpackage : xtal_trim_pkg
`default_nettype wire

/* core/xtal_trim_and_clock_calibration.sv */
// The implementer's own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "xtal_trim_consts.svh"

module xtal_trim_and_clock_calibration #(
	parameter int ADDR_W = 8,
	parameter int TICK_CYCLES = `TRIM_TICK_CYCLES
) (
	input wire logic i_clock,
	input wire logic i_nrst,
	input wire logic i_s_axi_awvalid,
	output logic o_s_axi_awready,
	input wire logic [ADDR_W-1:0] i_s_axi_awaddr,
	input wire logic [2:0] i_s_axi_awprot,
	input wire logic i_s_axi_wvalid,
	output logic o_s_axi_wready,
	input wire logic [31:0] i_s_axi_wdata,
	input wire logic [3:0] i_s_axi_wstrb,
	output logic o_s_axi_bvalid,
	input wire logic i_s_axi_bready,
	output logic [1:0] o_s_axi_bresp,
	input wire logic i_s_axi_arvalid,
	output logic o_s_axi_arready,
	input wire logic [ADDR_W-1:0] i_s_axi_araddr,
	input wire logic [2:0] i_s_axi_arprot,
	output logic o_s_axi_rvalid,
	input wire logic i_s_axi_rready,
	output logic [31:0] o_s_axi_rdata,
	output logic [1:0] o_s_axi_rresp,
	input wire xtal_trim_pkg::osc_ref_type i_osc_ref,
	output xtal_trim_pkg::cap_switch_type o_bank_a,
	output xtal_trim_pkg::cap_switch_type o_bank_b,
	output logic o_fast_crystal_enable,
	output logic [3:0] o_fast_rc_trim,
	output logic o_sys_clock_on_fast_rc,
	output logic o_sleep_clock_on_enhanced_rc,
	output logic [15:0] o_sleep_slot_length,
	output logic o_irq
);
	import xtal_trim_pkg::*;

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic [10:0] trim; // Stored trim word
		logic [10:0] applied; // Word currently at the oscillator
		cap_switch_type bank; // Registered switch drive
		logic xtal_en; // Fast crystal enable
		logic [3:0] trim_time; // Delay in 250 us ticks
		logic [3:0] settle_time; // Settle in 250 us ticks
		trim_seq_type seq; // Trim sequence state
		logic [15:0] tick_cnt; // 250 us divider
		logic [3:0] period_cnt; // Elapsed ticks in phase
		logic ready; // Trim applied flag
		logic settled; // Crystal settled flag
		logic on_rc; // System clock on fast RC, kept as a flop
		logic [1:0] ref_sel; // Reference source
		logic cal_busy; // Calibration running
		logic ref_prev; // Last reference sample
		logic [31:0] ref_n; // Periods to count
		logic [31:0] ref_seen; // Periods counted
		logic [31:0] meas; // Elapsed cycles
		logic [3:0] rc_trim; // Fast RC trim
		logic sleep_rcx; // Sleep on enhanced RC
		logic [15:0] slot_len; // Slot length, 8.8 sleep cycles
		logic [2:0] irq_st; // Sticky events
		logic [2:0] irq_mask; // Event enables
		logic irq; // Interrupt line
		logic aw_rdy;
		logic aw_got;
		logic [ADDR_W-1:0] aw_addr;
		logic w_rdy;
		logic w_got;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic ar_rdy;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} state_type;

	state_type s_q;
	state_type s_d;
	logic [1:0] rst_sync_q; // Reset release synchroniser
	logic rst_n; // Synchronised reset

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------

	// Thermometer decode of the three coarse bits
	function automatic logic [6:0] coarse_decode(input logic [2:0] code);
		logic [7:0] ones;
		ones = 8'(8'h01 << code) - 8'h01;
		if (code < 3'h2)
		begin
			coarse_decode = `COARSE_MIN;
		end
		else
		begin
			coarse_decode = ones[6:0];
		end
	endfunction : coarse_decode

	// Byte lane merge for AXI write strobes
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] strb);
		merge = old;
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i])
			begin
				merge[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
	endfunction : merge

	// ------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------

	// Asserts at once, releases two edges later
	always_ff @(posedge i_clock or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			rst_sync_q <= 2'h0;
		end
		else
		begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb
	begin
		logic [31:0] old;
		logic [31:0] wv;
		logic ref_now;
		logic tick;
		logic do_write;
		logic hit;
		logic [2:0] ev;
		logic [2:0] w1c;
		old = 32'h0;
		wv = 32'h0;
		ref_now = 1'b0;
		tick = 1'b0;
		do_write = 1'b0;
		hit = 1'b0;
		ev = 3'h0;
		w1c = 3'h0;
		s_d = s_q;

		// Channel captures, either order
		if (s_q.aw_rdy && i_s_axi_awvalid)
		begin
			s_d.aw_got = 1'b1;
			s_d.aw_addr = i_s_axi_awaddr;
		end
		if (s_q.w_rdy && i_s_axi_wvalid)
		begin
			s_d.w_got = 1'b1;
			s_d.w_data = i_s_axi_wdata;
			s_d.w_strb = i_s_axi_wstrb;
		end
		if (s_q.bvalid && i_s_axi_bready)
		begin
			s_d.bvalid = 1'b0;
		end
		do_write = s_q.aw_got && s_q.w_got && !s_q.bvalid;

		// 250 us divider, held at zero while the crystal is off
		if (s_q.seq == SEQ_TRIM_WAIT || s_q.seq == SEQ_SETTLE_WAIT)
		begin
			tick = (s_q.tick_cnt == 16'(TICK_CYCLES - 1));
			s_d.tick_cnt = tick ? 16'h0 : s_q.tick_cnt + 16'h1;
		end
		else
		begin
			s_d.tick_cnt = 16'h0;
		end

		// Automated trim sequence
		case (s_q.seq)
			SEQ_OFF:
			begin
				if (s_q.xtal_en)
				begin
					s_d.period_cnt = 4'h0;
					if (s_q.trim_time == 4'h0)
					begin
						// No delay: trim goes straight on
						s_d.ready = 1'b1;
						s_d.applied = s_q.trim;
						ev[0] = 1'b1;
						s_d.seq = SEQ_SETTLE_WAIT;
					end
					else
					begin
						s_d.seq = SEQ_TRIM_WAIT;
					end
				end
			end
			SEQ_TRIM_WAIT:
			begin
				if (tick)
				begin
					s_d.period_cnt = s_q.period_cnt + 4'h1;
					if (s_q.period_cnt + 4'h1 == s_q.trim_time)
					begin
						s_d.ready = 1'b1;
						s_d.applied = s_q.trim;
						ev[0] = 1'b1;
						s_d.period_cnt = 4'h0;
						s_d.seq = SEQ_SETTLE_WAIT;
					end
				end
			end
			SEQ_SETTLE_WAIT:
			begin
				// Zero settle count finishes on entry
				if (s_q.settle_time == 4'h0)
				begin
					s_d.settled = 1'b1;
					ev[1] = 1'b1;
					s_d.seq = SEQ_DONE;
				end
				else if (tick)
				begin
					s_d.period_cnt = s_q.period_cnt + 4'h1;
					if (s_q.period_cnt + 4'h1 == s_q.settle_time)
					begin
						s_d.settled = 1'b1;
						ev[1] = 1'b1;
						s_d.seq = SEQ_DONE;
					end
				end
			end
			SEQ_DONE:
			begin
				// Software steps go straight on once settled
				s_d.applied = s_q.trim;
			end
			default:
			begin
				s_d.seq = SEQ_OFF;
			end
		endcase

		// Crystal off drops both flags and the counters
		if (!s_q.xtal_en)
		begin
			s_d.seq = SEQ_OFF;
			s_d.ready = 1'b0;
			s_d.settled = 1'b0;
			s_d.period_cnt = 4'h0;
		end

		// Reference counter, cycles of the fast crystal clock
		case (s_q.ref_sel)
			2'h0: ref_now = i_osc_ref.slow_rc_osc;
			2'h1: ref_now = i_osc_ref.fast_rc_osc;
			2'h2: ref_now = i_osc_ref.slow_crystal;
			default: ref_now = i_osc_ref.enhanced_rc_osc;
		endcase
		s_d.ref_prev = ref_now;
		if (s_q.cal_busy)
		begin
			s_d.meas = s_q.meas + 32'h1;
			if (s_q.ref_n == 32'h0)
			begin
				s_d.cal_busy = 1'b0;
				ev[2] = 1'b1;
			end
			else if (ref_now && !s_q.ref_prev)
			begin
				s_d.ref_seen = s_q.ref_seen + 32'h1;
				if (s_q.ref_seen + 32'h1 == s_q.ref_n)
				begin
					s_d.cal_busy = 1'b0;
					ev[2] = 1'b1;
				end
			end
		end

		// Register write
		if (do_write)
		begin
			s_d.aw_got = 1'b0;
			s_d.w_got = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp = `RESP_OKAY;
			hit = 1'b1;
			case (s_q.aw_addr[7:0])
				`OFS_CAP_TRIM: old = {21'h0, s_q.trim};
				`OFS_TRIM_CTRL: old = {23'h0, s_q.xtal_en, s_q.settle_time, s_q.trim_time};
				`OFS_REF_SELECT: old = {29'h0, s_q.cal_busy, s_q.ref_sel};
				`OFS_REF_PERIODS: old = s_q.ref_n;
				`OFS_FAST_RC_CTRL: old = {28'h0, s_q.rc_trim};
				`OFS_IRQ_MASK: old = {29'h0, s_q.irq_mask};
				`OFS_SLEEP_CTRL: old = {s_q.slot_len, 15'h0, s_q.sleep_rcx};
				`OFS_SYS_STATUS, `OFS_MEASURED, `OFS_IRQ_STATUS: old = 32'h0;
				default: hit = 1'b0;
			endcase
			wv = merge(old, s_q.w_data, s_q.w_strb);
			case (s_q.aw_addr[7:0])
				`OFS_CAP_TRIM: s_d.trim = wv[10:0];
				`OFS_TRIM_CTRL:
				begin
					s_d.trim_time = wv[`TRIM_CTRL_DELAY_LSB +: 4];
					s_d.settle_time = wv[`TRIM_CTRL_SETTLE_LSB +: 4];
					s_d.xtal_en = wv[`TRIM_CTRL_XTAL_EN_BIT];
				end
				`OFS_REF_SELECT:
				begin
					// A code with the start bit restarts any run
					s_d.ref_sel = wv[1:0];
					if (wv[`REF_SEL_START_BIT])
					begin
						s_d.cal_busy = 1'b1;
						s_d.meas = 32'h0;
						s_d.ref_seen = 32'h0;
					end
				end
				`OFS_REF_PERIODS: s_d.ref_n = wv;
				`OFS_FAST_RC_CTRL: s_d.rc_trim = wv[3:0];
				`OFS_IRQ_STATUS: w1c = wv[2:0];
				`OFS_IRQ_MASK: s_d.irq_mask = wv[2:0];
				`OFS_SLEEP_CTRL:
				begin
					s_d.sleep_rcx = wv[`SLEEP_CTRL_RCX_BIT];
					s_d.slot_len = wv[`SLEEP_CTRL_SLOT_LSB +: 16];
				end
				default: s_d.bresp = `RESP_SLVERR;
			endcase
			if (!hit)
			begin
				s_d.bresp = `RESP_SLVERR;
			end
		end

		// Register read, answered one edge after the address
		if (s_q.rvalid && i_s_axi_rready)
		begin
			s_d.rvalid = 1'b0;
		end
		if (s_q.ar_rdy && i_s_axi_arvalid)
		begin
			s_d.rvalid = 1'b1;
			s_d.rresp = `RESP_OKAY;
			case (i_s_axi_araddr[7:0])
				`OFS_CAP_TRIM: s_d.rdata = {21'h0, s_q.trim};
				`OFS_TRIM_CTRL:
					s_d.rdata = {23'h0, s_q.xtal_en, s_q.settle_time, s_q.trim_time};
				`OFS_SYS_STATUS: s_d.rdata = {29'h0, s_q.cal_busy, s_q.settled, s_q.ready};
				`OFS_REF_SELECT: s_d.rdata = {29'h0, s_q.cal_busy, s_q.ref_sel};
				`OFS_REF_PERIODS: s_d.rdata = s_q.ref_n;
				`OFS_MEASURED: s_d.rdata = s_q.meas;
				`OFS_FAST_RC_CTRL: s_d.rdata = {28'h0, s_q.rc_trim};
				`OFS_IRQ_STATUS: s_d.rdata = {29'h0, s_q.irq_st};
				`OFS_IRQ_MASK: s_d.rdata = {29'h0, s_q.irq_mask};
				`OFS_SLEEP_CTRL: s_d.rdata = {s_q.slot_len, 15'h0, s_q.sleep_rcx};
				default:
				begin
					s_d.rdata = 32'h0;
					s_d.rresp = `RESP_SLVERR;
				end
			endcase
		end

		// Sticky events: a new event beats a same-cycle clear
		s_d.irq_st = (s_q.irq_st & ~w1c) | ev;
		s_d.irq = |(s_d.irq_st & s_d.irq_mask);

		// Readies: one item per channel until answered
		s_d.aw_rdy = !s_d.aw_got && !s_d.bvalid;
		s_d.w_rdy = !s_d.w_got && !s_d.bvalid;
		s_d.ar_rdy = !s_d.rvalid;

		// Both banks follow one applied word
		s_d.bank.fine = s_d.applied[7:0];
		s_d.bank.coarse = coarse_decode(s_d.applied[10:8]);

		// Clock select follows the settled flag in the same edge
		s_d.on_rc = !s_d.settled;
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge i_clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_q <= '0;
			s_q.trim <= `CAP_TRIM_RESET;
			s_q.applied <= `CAP_TRIM_RESET;
			s_q.bank.coarse <= `COARSE_MIN;
			s_q.seq <= SEQ_OFF;
			s_q.rc_trim <= `FAST_RC_TRIM_RESET;
			s_q.slot_len <= `SLOT_LEN_RESET;
			s_q.on_rc <= 1'b1; // Never settled while in reset
		end
		else
		begin
			s_q <= s_d;
		end
	end

	// ------------------------------------------------------------
	// Outputs, all from flops
	// ------------------------------------------------------------
	assign o_s_axi_awready = s_q.aw_rdy;
	assign o_s_axi_wready = s_q.w_rdy;
	assign o_s_axi_bvalid = s_q.bvalid;
	assign o_s_axi_bresp = s_q.bresp;
	assign o_s_axi_arready = s_q.ar_rdy;
	assign o_s_axi_rvalid = s_q.rvalid;
	assign o_s_axi_rdata = s_q.rdata;
	assign o_s_axi_rresp = s_q.rresp;
	assign o_bank_a = s_q.bank;
	assign o_bank_b = s_q.bank;
	assign o_fast_crystal_enable = s_q.xtal_en;
	assign o_fast_rc_trim = s_q.rc_trim;
	// Fast RC runs the system until the crystal is settled
	assign o_sys_clock_on_fast_rc = s_q.on_rc;
	// Slow crystal by default, no trim path to it
	assign o_sleep_clock_on_enhanced_rc = s_q.sleep_rcx;
	assign o_sleep_slot_length = s_q.slot_len;
	assign o_irq = s_q.irq;

endmodule : xtal_trim_and_clock_calibration

`default_nettype wire

/* dv/osc_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Oscillator stand-ins
// ----------------------------------------
module osc_model #(
	parameter int H0 = 3,
	parameter int H1 = 4,
	parameter int H2 = 6,
	parameter int H3 = 9
) (
	input wire logic i_clock,
	output var xtal_trim_pkg::osc_ref_type o_ref
);
	import xtal_trim_pkg::*;
	localparam int HALF [4] = '{H0, H1, H2, H3};
	int cnt [4] = '{0, 0, 0, 0}; // Half period counters
	logic [3:0] lvl = 4'h0; // Index is select code minus four
	// Unequal periods, so a wrong source gives a wrong count
	always @(posedge i_clock)
	begin
		for (int k = 0; k < 4; k++)
		begin
			cnt[k] <= (cnt[k] >= HALF[k] - 1) ? 0 : cnt[k] + 1;
			if (cnt[k] >= HALF[k] - 1)
				lvl[k] <= !lvl[k];
		end
	end
	assign o_ref = {lvl[0], lvl[1], lvl[2], lvl[3]};
endmodule : osc_model
`default_nettype wire

/* dv/xtal_trim_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module xtal_trim_checker (
	input wire logic i_clock,
	input wire logic i_nrst,
	input wire xtal_trim_pkg::cap_switch_type o_bank_a,
	input wire xtal_trim_pkg::cap_switch_type o_bank_b,
	input wire logic o_s_axi_awready,
	input wire logic o_s_axi_wready,
	input wire logic o_s_axi_arready,
	input wire logic o_s_axi_bvalid,
	input wire logic i_s_axi_bready,
	input wire logic o_s_axi_rvalid,
	input wire logic i_s_axi_rready,
	input wire logic o_fast_crystal_enable,
	input wire logic o_sys_clock_on_fast_rc,
	input wire logic [3:0] o_fast_rc_trim
);
	import xtal_trim_pkg::*;
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_nrst);
	banks_match_a: assert property (o_bank_a == o_bank_b)
		else $error("banks differ");
	coarse_therm_a: assert property (o_bank_a.coarse[0]
		&& (o_bank_a.coarse & (o_bank_a.coarse + 7'h01)) == 7'h00)
		else $error("coarse not thermometer");
	bvalid_stands_a: assert property (o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid)
		else $error("bvalid dropped early");
	rvalid_stands_a: assert property (o_s_axi_rvalid && !i_s_axi_rready |=> o_s_axi_rvalid)
		else $error("rvalid dropped early");
	bvalid_ends_a: assert property (o_s_axi_bvalid && i_s_axi_bready |=> !o_s_axi_bvalid)
		else $error("bvalid held after handshake");
	write_refused_a: assert property (o_s_axi_bvalid |-> !o_s_axi_awready && !o_s_axi_wready)
		else $error("write taken during response");
	read_refused_a: assert property (o_s_axi_rvalid |-> !o_s_axi_arready)
		else $error("read taken during response");
	// Slack of six covers the edge between disable and the clock select
	rc_clock_a: assert property (!o_fast_crystal_enable [*6] |-> o_sys_clock_on_fast_rc)
		else $error("system clock left fast rc");
	off_to_rc_a: assert property ($fell(o_fast_crystal_enable) |-> ##[0:2] o_sys_clock_on_fast_rc)
		else $error("disable did not clear settled");
	reset_values_a: assert property ($rose(i_nrst) |-> o_fast_rc_trim == 4'h0
		&& o_bank_a.coarse == 7'h01 && !o_fast_crystal_enable)
		else $error("bad reset values");
endmodule : xtal_trim_checker
bind xtal_trim_and_clock_calibration xtal_trim_checker xtal_trim_checker_i (.i_clock, .i_nrst,
	.o_bank_a, .o_bank_b, .o_s_axi_awready, .o_s_axi_wready, .o_s_axi_arready,
	.o_s_axi_bvalid, .i_s_axi_bready, .o_s_axi_rvalid, .i_s_axi_rready,
	.o_fast_crystal_enable, .o_sys_clock_on_fast_rc, .o_fast_rc_trim);
`default_nettype wire

/* dv/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import xtal_trim_pkg::*;
	localparam int TICK = 10; // Short tick keeps the run brief
	localparam int NREF = 4;
	localparam int H [4] = '{3, 4, 6, 9};
	// Coarse field moves one step a row
	localparam logic [10:0] TW [8] = '{11'h7FF, 11'h6FF, 11'h5FF, 11'h400,
		11'h3FF, 11'h2A5, 11'h1FF, 11'h000};
	localparam logic [6:0] TC [8] = '{7'h7F, 7'h3F, 7'h1F, 7'h0F, 7'h07, 7'h03, 7'h01, 7'h01};
	logic i_clock = 1'b0;
	logic i_nrst = 1'b0;
	logic i_s_axi_awvalid = 1'b0, i_s_axi_wvalid = 1'b0, i_s_axi_bready = 1'b0;
	logic i_s_axi_arvalid = 1'b0, i_s_axi_rready = 1'b0;
	logic [7:0] i_s_axi_awaddr = 8'h00, i_s_axi_araddr = 8'h00;
	logic [31:0] i_s_axi_wdata = 32'h0;
	logic [3:0] i_s_axi_wstrb = 4'hF;
	logic [2:0] i_s_axi_awprot = 3'h0, i_s_axi_arprot = 3'h0;
	logic o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid;
	logic [1:0] o_s_axi_bresp, o_s_axi_rresp, resp;
	logic [31:0] o_s_axi_rdata, rdat;
	osc_ref_type i_osc_ref;
	cap_switch_type o_bank_a, o_bank_b;
	logic o_fast_crystal_enable, o_sys_clock_on_fast_rc, o_sleep_clock_on_enhanced_rc, o_irq;
	logic [3:0] o_fast_rc_trim;
	logic [15:0] o_sleep_slot_length;
	int err_count = 0, comparisons = 0, cyc = 0;
	xtal_trim_and_clock_calibration #(.TICK_CYCLES(TICK)) xtal_trim_and_clock_calibration_i (
		.i_clock, .i_nrst, .i_s_axi_awvalid, .o_s_axi_awready, .i_s_axi_awaddr,
		.i_s_axi_awprot, .i_s_axi_wvalid, .o_s_axi_wready, .i_s_axi_wdata, .i_s_axi_wstrb,
		.o_s_axi_bvalid, .i_s_axi_bready, .o_s_axi_bresp, .i_s_axi_arvalid, .o_s_axi_arready,
		.i_s_axi_araddr, .i_s_axi_arprot, .o_s_axi_rvalid, .i_s_axi_rready, .o_s_axi_rdata,
		.o_s_axi_rresp, .i_osc_ref, .o_bank_a, .o_bank_b, .o_fast_crystal_enable,
		.o_fast_rc_trim, .o_sys_clock_on_fast_rc, .o_sleep_clock_on_enhanced_rc,
		.o_sleep_slot_length, .o_irq);
	osc_model #(.H0(H[0]), .H1(H[1]), .H2(H[2]), .H3(H[3])) osc_model_i (.i_clock, .o_ref(i_osc_ref));
	initial
	begin
		forever #12.5 i_clock = ~i_clock;
	end
	// ----------------------------------------
	// Compare, report, close
	// ----------------------------------------
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	task automatic end_sim;
		$display("mismatches %0d comparisons %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : end_sim
	// Hang guard, well above the planned run
	always @(posedge i_clock)
	begin
		cyc <= cyc + 1;
		if (cyc == 6000)
		begin
			err_count++;
			end_sim;
		end
	end
	// ----------------------------------------
	// Bus tasks: look at negedge, act at posedge
	// ----------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic ta, tw, tb;
		@(posedge i_clock);
		i_s_axi_awaddr <= a;
		i_s_axi_wdata <= d;
		i_s_axi_awvalid <= 1'b1;
		i_s_axi_wvalid <= 1'b1;
		i_s_axi_bready <= 1'b1;
		do
		begin
			@(negedge i_clock);
			ta = i_s_axi_awvalid && o_s_axi_awready;
			tw = i_s_axi_wvalid && o_s_axi_wready;
			tb = o_s_axi_bvalid;
			resp = o_s_axi_bresp;
			@(posedge i_clock);
			if (ta) i_s_axi_awvalid <= 1'b0;
			if (tw) i_s_axi_wvalid <= 1'b0;
			if (tb) i_s_axi_bready <= 1'b0;
		end
		while (!tb);
	endtask : wr
	task automatic rd(input logic [7:0] a);
		logic ta, tr;
		@(posedge i_clock);
		i_s_axi_araddr <= a;
		i_s_axi_arvalid <= 1'b1;
		i_s_axi_rready <= 1'b1;
		do
		begin
			@(negedge i_clock);
			ta = i_s_axi_arvalid && o_s_axi_arready;
			tr = o_s_axi_rvalid;
			rdat = o_s_axi_rdata;
			resp = o_s_axi_rresp;
			@(posedge i_clock);
			if (ta) i_s_axi_arvalid <= 1'b0;
			if (tr) i_s_axi_rready <= 1'b0;
		end
		while (!tr);
	endtask : rd
	initial
	begin
		logic [31:0] m;
		int lo;
		int hi;
		repeat (12) @(posedge i_clock);
		i_nrst <= 1'b1;
		repeat (4) @(posedge i_clock);
		rd(8'h18);
		chk("rc_trim_reg", rdat, 32'h0);
		rd(8'h24);
		chk("sleep_reg", rdat, 32'h147B0000);
		chk("sys_on_rc", o_sys_clock_on_fast_rc, 32'h1);
		// Trim word held back until the delay ticks run out
		wr(8'h00, 32'h7FF);
		wr(8'h04, 32'h123);
		chk("xtal_on", o_fast_crystal_enable, 32'h1);
		repeat (2 * TICK) @(posedge i_clock);
		rd(8'h08);
		chk("not_ready", rdat[0], 32'h0);
		chk("bank_held", o_bank_a, 32'h100);
		repeat (TICK - 2) @(posedge i_clock);
		rd(8'h08);
		chk("ready", rdat[1:0], 32'h1);
		chk("bank_applied", o_bank_a, 32'h7FFF);
		repeat (2 * TICK) @(posedge i_clock);
		rd(8'h08);
		chk("settled", rdat[1:0], 32'h3);
		chk("sys_on_xtal", o_sys_clock_on_fast_rc, 32'h0);
		for (int i = 0; i < 8; i++)
		begin
			wr(8'h00, {21'h0, TW[i]});
			repeat (2) @(posedge i_clock);
			chk("bank_a", o_bank_a, {TC[i], TW[i][7:0]});
			chk("bank_b", o_bank_b, {TC[i], TW[i][7:0]});
			rd(8'h00);
			chk("trim_reg", rdat, {21'h0, TW[i]});
		end
		// Disable, then restart with no delay
		wr(8'h04, 32'h0);
		chk("xtal_off", o_fast_crystal_enable, 32'h0);
		repeat (2) @(posedge i_clock);
		rd(8'h08);
		chk("flags_clear", rdat[1:0], 32'h0);
		chk("back_on_rc", o_sys_clock_on_fast_rc, 32'h1);
		// Trim written while off waits for the next start
		wr(8'h00, 32'h0AB);
		repeat (2) @(posedge i_clock);
		chk("bank_off", o_bank_a, 32'h100);
		wr(8'h04, 32'h100);
		rd(8'h08);
		chk("zero_delay", rdat[1:0], 32'h3);
		chk("bank_now", o_bank_a, 32'h1AB);
		for (int c = 4; c < 8; c++)
		begin
			wr(8'h10, NREF);
			wr(8'h0C, c);
			rdat = 32'h4;
			while (rdat[2])
				rd(8'h0C);
			rd(8'h14);
			m = rdat;
			lo = (NREF - 1) * 2 * H[c - 4];
			hi = NREF * 2 * H[c - 4] + 3;
			chk("cycles", m >= lo && m <= hi, 32'h1);
		end
		// Events pending but masked, then the calibration event unmasked and cleared
		chk("irq_masked", o_irq, 32'h0);
		rd(8'h1C);
		chk("irq_status", rdat, 32'h7);
		wr(8'h20, 32'h4);
		repeat (2) @(posedge i_clock);
		chk("irq_on", o_irq, 32'h1);
		wr(8'h1C, 32'h4);
		repeat (2) @(posedge i_clock);
		chk("irq_off", o_irq, 32'h0);
		rd(8'h1C);
		chk("irq_kept", rdat, 32'h3);
		wr(8'h14, 32'h0);
		rd(8'h14);
		chk("cycles_ro", rdat, m);
		rd(8'h40);
		chk("bad_rresp", resp, 32'h2);
		chk("bad_rdata", rdat, 32'h0);
		wr(8'h40, 32'hFFFFFFFF);
		chk("bad_bresp", resp, 32'h2);
		wr(8'h18, 32'hA);
		@(negedge i_clock);
		chk("rc_trim", o_fast_rc_trim, 32'hA);
		@(posedge i_clock);
		i_s_axi_wstrb <= 4'hC;
		wr(8'h24, 32'h12340001);
		i_s_axi_wstrb <= 4'hF;
		rd(8'h24);
		chk("strobe", rdat, 32'h12340000);
		chk("slot_pin", o_sleep_slot_length, 32'h1234);
		wr(8'h24, 32'h1);
		@(negedge i_clock);
		chk("rcx_sleep", o_sleep_clock_on_enhanced_rc, 32'h1);
		// Second reset in mid-run
		@(posedge i_clock);
		i_nrst <= 1'b0;
		repeat (3) @(posedge i_clock);
		chk("rst_rc_trim", o_fast_rc_trim, 32'h0);
		chk("rst_bank", o_bank_a, 32'h100);
		chk("rst_slot", o_sleep_slot_length, 32'h147B);
		chk("rst_xtal_en", o_fast_crystal_enable, 32'h0);
		i_nrst <= 1'b1;
		repeat (5) @(posedge i_clock);
		// Bus must answer again after the mid-run reset
		rd(8'h18);
		chk("rst_rc_reg", rdat, 32'h0);
		end_sim;
	end
endmodule : tb_top
`default_nettype wire
